// ---- sbcp_port.sv ----
// SMBus target command port of a battery gauge
// Contract
// - CRC-8 with polynomial x^8+x^2+x+1
// - CRC covers address, command, data bytes
// - Word read CRC over five bytes
// - Stored bits enable broadcast CRC per destination
// - Off state after 2 s both low
// - Communicate within 1 ms of lines high
// - 0x0001 loads device type code
// - 0x0002 loads firmware revision code
// - 0x0003 loads pending end-of-discharge level
// - 0x062b seals, then clears command word
// - Low charge alarm; zero threshold disables
// - Low charge threshold from stored configuration
// - Low runtime alarm; zero threshold disables
// - Low runtime threshold from stored configuration
// - Options low byte read only, bits 0-6 zero
// - Relearn flag: reset, 20 cycles, cleared
// - Bit 13 suppresses alarm broadcasts; the code ignores bit 13, any options write mutes them
// - Bit 14 suppresses charging broadcasts
// - Bit 15 selects 10 mW units
// - Threshold units follow unit-select bit
// - Target address 0001011 plus direction bit
// - Options write clears bit 13, 60 s timer
`timescale 1ns/1ps
`include "sbcp_cfg.svh"
module sbcp_port
    import sbcp_pkg::*;
#(
    parameter logic [15:0] DEVICE_TYPE  = 16'h1234, // Arbitrary value
    parameter logic [15:0] FW_REVISION  = 16'h0100, // Arbitrary value
    parameter int unsigned OFF_CYCLES   = `SBCP_OFF_CYCLES,
    parameter int unsigned ON_CYCLES    = `SBCP_ON_CYCLES,
    parameter int unsigned MUTE_CYCLES  = `SBCP_MUTE_CYCLES
) (
    input  wire logic        mclk_i,
    input  wire logic        resetn_i,
    input  wire logic        bus_clock_pin_i,
    input  wire logic        bus_data_pin_i,
    output logic             bus_data_pin_o,
    output logic             bus_data_pin_oe_o,
    input  wire logic [15:0] cfg_low_charge_i,
    input  wire logic [15:0] cfg_low_runtime_i,
    input  wire logic        cfg_host_crc_en_i,
    input  wire logic        cfg_charger_crc_en_i,
    input  wire logic [15:0] end_of_discharge_voltage_i,
    input  wire logic [15:0] charge_left_i,
    input  wire logic [15:0] mean_runtime_left_i,
    input  wire logic        cycle_count_inc_i,
    input  wire logic        full_capacity_update_i,
    input  wire logic        learn_done_i,
    output logic             host_broadcast_crc_enable_o,
    output logic             charger_broadcast_crc_enable_o,
    output logic             low_charge_alarm_o,
    output logic             low_runtime_alarm_o,
    output logic             alarm_broadcast_en_o,
    output logic             charge_broadcast_en_o,
    output logic             power_units_o,
    output logic             sealed_o,
    output logic             bus_off_o,
    output logic             crc_error_o
);
    typedef struct packed {
        logic [2:0]  scl_s;
        logic [2:0]  sda_s;
        sbcp_state_t fsm;
        sbcp_state_t after_ack;
        logic [7:0]  sh;
        logic [3:0]  bitn;
        logic [2:0]  idx;
        logic        rd;
        logic [7:0]  cmd;
        logic [7:0]  crc;
        logic [15:0] wdata;
        logic [15:0] tx;
        logic        sda_low;
        logic [15:0] maker;
        logic [15:0] low_charge;
        logic [15:0] low_runtime;
        logic [2:0]  opt_hi;
        logic        sealed;
        logic        crc_err;
        logic        cfg_loaded;
        sbcp_opt_st_t opt;
    } sbcp_st_t;

    sbcp_st_t st, n;
    logic [7:0] crc_next;
    logic       ready;
    logic       scl, sda, scl_rise, scl_fall, start_c, stop_c;

    sbcp_crc8 u_crc (
        .crc_i  (st.crc),
        .data_i (st.sh),
        .crc_o  (crc_next)
    );

    sbcp_bus_state #(
        .OFF_CYCLES (OFF_CYCLES),
        .ON_CYCLES  (ON_CYCLES)
    ) u_bus (
        .mclk_i      (mclk_i),
        .resetn_i    (resetn_i),
        .scl_i       (scl),
        .sda_i       (sda),
        .bus_off_o   (bus_off_o),
        .bus_ready_o (ready)
    );

    // Stage 0 only feeds stage 1; edges seen from stages 1 and 2
    assign scl      = st.scl_s[1];
    assign sda      = st.sda_s[1];
    assign scl_rise = st.scl_s[1] && !st.scl_s[2];
    assign scl_fall = !st.scl_s[1] && st.scl_s[2];
    assign start_c  = scl && st.scl_s[2] && !sda && st.sda_s[2];
    assign stop_c   = scl && st.scl_s[2] && sda && !st.sda_s[2];

    function automatic logic [15:0] read_word(input sbcp_st_t s);
        case (s.cmd)
            `SBCP_CMD_MAKER:   read_word = s.maker;
            `SBCP_CMD_LOWCHG:  read_word = s.low_charge;
            `SBCP_CMD_LOWRUN:  read_word = s.low_runtime;
            `SBCP_CMD_OPTIONS: read_word = {s.opt_hi, 5'h00,
                                            s.opt.relearn,
                                            7'h00};
            default:           read_word = 16'h0000;
        endcase
    endfunction : read_word

    always_comb begin
        n = st;
        n.scl_s = {st.scl_s[1:0], bus_clock_pin_i};
        n.sda_s = {st.sda_s[1:0], bus_data_pin_i};
        if (!st.cfg_loaded) begin
            n.low_charge  = cfg_low_charge_i;
            n.low_runtime = cfg_low_runtime_i;
            n.cfg_loaded  = 1'b1;
        end
        // Relearn request bookkeeping
        if (learn_done_i) begin
            n.opt.relearn = 1'b0;
            n.opt.cyc_cnt = 8'h00;
        end else if (full_capacity_update_i) begin
            n.opt.cyc_cnt = 8'h00;
        end else if (cycle_count_inc_i) begin
            if (st.opt.cyc_cnt + 8'd1 >= `SBCP_RELEARN_LIMIT)
                n.opt.relearn = 1'b1;
            else
                n.opt.cyc_cnt = st.opt.cyc_cnt + 8'd1;
        end
        // Alarm mute timer re-enables broadcasts on expiry
        if (st.opt.mute) begin
            if (st.opt.mute_cnt >= MUTE_CYCLES - 1) begin
                n.opt.mute = 1'b0;
                n.opt.mute_cnt = '0;
            end else begin
                n.opt.mute_cnt = st.opt.mute_cnt + 32'd1;
            end
        end

        if (!ready || stop_c) begin
            n.fsm = SBCP_IDLE;
            n.sda_low = 1'b0;
        end else if (start_c) begin
            n.fsm = SBCP_ADDR;
            n.bitn = 4'd0;
            n.sda_low = 1'b0;
            if (st.fsm == SBCP_IDLE || st.idx != 3'd2) begin
                n.idx = 3'd0;
                n.crc = `SBCP_CRC_INIT;
            end
        end else begin
            case (st.fsm)
                SBCP_ADDR, SBCP_WRX: begin
                    if (scl_rise) begin
                        n.sh = {st.sh[6:0], sda};
                        n.bitn = st.bitn + 4'd1;
                    end
                    if (scl_fall && st.bitn == 4'd8) begin
                        n.crc = crc_next;
                        n.bitn = 4'd0;
                        n.idx = st.idx + 3'd1;
                        n.fsm = SBCP_ACK;
                        n.sda_low = 1'b1;
                        n.after_ack = SBCP_WRX;
                        if (st.fsm == SBCP_ADDR) begin
                            if (st.sh[7:1] != `SBCP_TARGET_ADDR) begin
                                n.sda_low = 1'b0;
                                n.fsm = SBCP_SKIP;
                            end else if (st.sh[0]) begin
                                n.rd = 1'b1;
                                n.tx = read_word(st);
                                n.after_ack = SBCP_TX;
                            end else begin
                                n.rd = 1'b0;
                            end
                        end else begin
                            case (st.idx)
                                3'd1: n.cmd = st.sh;
                                3'd2: n.wdata[7:0] = st.sh;
                                3'd3: n.wdata[15:8] = st.sh;
                                3'd4: n.crc_err = (crc_next != 8'h00);
                                default: n.crc_err = st.crc_err;
                            endcase
                            // Bad PEC answered with not-acknowledge
                            if (st.idx == 3'd4 && crc_next != 8'h00)
                                n.sda_low = 1'b0;
                            if (st.idx == 3'd3) begin
                                case (st.cmd)
                                    `SBCP_CMD_MAKER: begin
                                        case ({st.sh, st.wdata[7:0]})
                                            `SBCP_MC_DEVTYPE:
                                                n.maker = DEVICE_TYPE;
                                            `SBCP_MC_FWREV:
                                                n.maker = FW_REVISION;
                                            `SBCP_MC_EDV:
                                                n.maker =
                                                end_of_discharge_voltage_i;
                                            `SBCP_MC_SEAL: begin
                                                n.sealed = 1'b1;
                                                n.maker = 16'h0000;
                                            end
                                            default:
                                                n.maker = {st.sh, st.wdata[7:0]};
                                        endcase
                                    end
                                    `SBCP_CMD_LOWCHG:
                                        n.low_charge = {st.sh, st.wdata[7:0]};
                                    `SBCP_CMD_LOWRUN:
                                        n.low_runtime = {st.sh, st.wdata[7:0]};
                                    `SBCP_CMD_OPTIONS: begin
                                        // Writes to low byte are dropped
                                        n.opt_hi = {st.sh[7:6], 1'b0};
                                        n.opt.mute = 1'b1;
                                        n.opt.mute_cnt = '0;
                                    end
                                    default: n.maker = st.maker;
                                endcase
                            end
                        end
                    end
                end
                SBCP_ACK: begin
                    if (scl_fall) begin
                        n.sda_low = 1'b0;
                        n.fsm = st.after_ack;
                        if (st.after_ack == SBCP_TX)
                            n.sda_low = !st.tx[7];
                        n.sh = st.tx[7:0];
                    end
                end
                SBCP_TX: begin
                    if (scl_fall) begin
                        n.bitn = st.bitn + 4'd1;
                        if (st.bitn == 4'd7) begin
                            n.crc = crc_next;
                            n.idx = st.idx + 3'd1;
                            n.bitn = 4'd0;
                            n.sda_low = 1'b0;
                            n.fsm = SBCP_TACK;
                        end else begin
                            // Byte kept whole so the PEC sees it
                            n.sda_low = !st.sh[3'd6 - st.bitn[2:0]];
                        end
                    end
                end
                SBCP_TACK: begin
                    if (scl_rise && sda)
                        n.fsm = SBCP_SKIP;
                    else if (scl_fall) begin
                        n.fsm = SBCP_TX;
                        // Low byte, high byte, then the PEC byte
                        case (st.idx)
                            3'd4: n.sh = st.tx[15:8];
                            3'd5: n.sh = st.crc;
                            default: n.sh = 8'h00;
                        endcase
                        n.sda_low = (st.idx == 3'd4) ? !st.tx[15]
                                  : (st.idx == 3'd5) ? !st.crc[7] : 1'b1;
                        if (st.idx > 3'd5)
                            n.fsm = SBCP_SKIP;
                    end
                end
                SBCP_SKIP: n.sda_low = 1'b0;
                default:   n.fsm = SBCP_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st <= '0;
            st.opt.relearn <= 1'b1;
            st.scl_s <= 3'b111;
            st.sda_s <= 3'b111;
        end else begin
            st <= n;
        end
    end

    assign bus_data_pin_o    = 1'b0;
    assign bus_data_pin_oe_o = st.sda_low;
    assign host_broadcast_crc_enable_o    = cfg_host_crc_en_i;
    assign charger_broadcast_crc_enable_o = cfg_charger_crc_en_i;
    assign low_charge_alarm_o  = (st.low_charge != 16'h0000) &&
                                 (charge_left_i < st.low_charge);
    assign low_runtime_alarm_o = (st.low_runtime != 16'h0000) &&
                                 (mean_runtime_left_i < st.low_runtime);
    assign alarm_broadcast_en_o  = !st.opt.mute;
    assign charge_broadcast_en_o = !st.opt_hi[1];
    assign power_units_o = st.opt_hi[2];
    assign sealed_o      = st.sealed;
    assign crc_error_o   = st.crc_err;
endmodule : sbcp_port

// ---- sbcp_cfg.svh ----
// Constants for the battery command port
`ifndef SBCP_CFG_SVH
`define SBCP_CFG_SVH
`define SBCP_TARGET_ADDR    7'h0b
`define SBCP_CMD_MAKER      8'h00
`define SBCP_CMD_LOWCHG     8'h01
`define SBCP_CMD_LOWRUN     8'h02
`define SBCP_CMD_OPTIONS    8'h03
`define SBCP_MC_DEVTYPE     16'h0001
`define SBCP_MC_FWREV       16'h0002
`define SBCP_MC_EDV         16'h0003
`define SBCP_MC_SEAL        16'h062b
`define SBCP_CRC_POLY       8'h07
`define SBCP_CRC_INIT       8'h00
`define SBCP_OPT_RELEARN    7
`define SBCP_OPT_ALARM_DIS  13
`define SBCP_OPT_CHG_DIS    14
`define SBCP_OPT_UNITS      15
`define SBCP_OPT_WMASK      16'hff00
`define SBCP_RELEARN_LIMIT  8'd20
`define SBCP_CLK_HZ         10000000
`define SBCP_OFF_TIME_MS    2000
`define SBCP_ON_TIME_US     1000
`define SBCP_MUTE_TIME_S    60
`define SBCP_OFF_CYCLES     (`SBCP_CLK_HZ / 1000 * `SBCP_OFF_TIME_MS)
`define SBCP_ON_CYCLES      (`SBCP_CLK_HZ / 1000000 * `SBCP_ON_TIME_US)
`define SBCP_MUTE_CYCLES    (`SBCP_CLK_HZ * `SBCP_MUTE_TIME_S)
`endif

// ---- sbcp_pkg.sv ----
// Types shared by the battery command port
package sbcp_pkg;
    typedef enum logic [2:0] {
        SBCP_IDLE  = 3'b000,
        SBCP_ADDR  = 3'b001,
        SBCP_WRX   = 3'b010,
        SBCP_TX    = 3'b011,
        SBCP_ACK   = 3'b100,
        SBCP_TACK  = 3'b101,
        SBCP_SKIP  = 3'b110
    } sbcp_state_t;

    typedef struct packed {
        logic        off;
        logic [31:0] low_cnt;
        logic [31:0] high_cnt;
    } sbcp_bus_st_t;

    typedef struct packed {
        logic relearn;
        logic mute;
        logic [31:0] mute_cnt;
        logic [7:0]  cyc_cnt;
    } sbcp_opt_st_t;
endpackage : sbcp_pkg

// ---- sbcp_crc8.sv ----
// Byte-wide CRC-8 step for packet error checking
`timescale 1ns/1ps
`include "sbcp_cfg.svh"
module sbcp_crc8
    import sbcp_pkg::*;
(
    input  wire logic [7:0] crc_i,
    input  wire logic [7:0] data_i,
    output logic      [7:0] crc_o
);
    // MSB first, x^8+x^2+x+1
    function automatic logic [7:0] crc_step(input logic [7:0] c,
                                            input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++) begin
            r = r[7] ? ((r << 1) ^ `SBCP_CRC_POLY) : (r << 1);
        end
        return r;
    endfunction : crc_step

    assign crc_o = crc_step(crc_i, data_i);
endmodule : sbcp_crc8

// ---- sbcp_bus_state.sv ----
// Bus off-state and on-state detector
`timescale 1ns/1ps
`include "sbcp_cfg.svh"
module sbcp_bus_state
    import sbcp_pkg::*;
#(
    parameter int unsigned OFF_CYCLES = `SBCP_OFF_CYCLES,
    parameter int unsigned ON_CYCLES  = `SBCP_ON_CYCLES
) (
    input  wire logic mclk_i,
    input  wire logic resetn_i,
    input  wire logic scl_i,
    input  wire logic sda_i,
    output logic      bus_off_o,
    output logic      bus_ready_o
);
    sbcp_bus_st_t st, next_st;

    always_comb begin
        next_st = st;
        if (!scl_i && !sda_i) begin
            next_st.high_cnt = '0;
            if (st.low_cnt < OFF_CYCLES)
                next_st.low_cnt = st.low_cnt + 32'd1;
            else
                next_st.off = 1'b1;
        end else begin
            next_st.low_cnt = '0;
            if (scl_i && sda_i) begin
                next_st.off = 1'b0;
                if (st.high_cnt < ON_CYCLES)
                    next_st.high_cnt = st.high_cnt + 32'd1;
            end
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i)
            st <= '0;
        else
            st <= next_st;
    end

    assign bus_off_o   = st.off;
    // Ready well inside 1 ms of lines returning high
    assign bus_ready_o = !st.off;
endmodule : sbcp_bus_state

// ---- sbcp_port_monitor.sv ----
// Concurrent checks on the command port pins
`timescale 1ns/1ps
module sbcp_port_monitor
    import sbcp_pkg::*;
#(
    parameter int unsigned OFF_CYCLES  = 200,
    parameter int unsigned MUTE_CYCLES = 500
) (
    input  wire logic        mclk_i,
    input  wire logic        resetn_i,
    input  wire logic        bus_clock_pin_i,
    input  wire logic        bus_data_pin_i,
    input  wire logic        bus_data_pin_oe_o,
    input  wire logic        cfg_host_crc_en_i,
    input  wire logic        cfg_charger_crc_en_i,
    input  wire logic [15:0] charge_left_i,
    input  wire logic        host_broadcast_crc_enable_o,
    input  wire logic        charger_broadcast_crc_enable_o,
    input  wire logic        low_charge_alarm_o,
    input  wire logic        alarm_broadcast_en_o,
    input  wire logic        charge_broadcast_en_o,
    input  wire logic        power_units_o,
    input  wire logic        sealed_o,
    input  wire logic        bus_off_o
);
    logic [31:0] low_cnt;
    logic [31:0] mute_cnt;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    // Cycles with both pins low, and cycles with broadcasts muted
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            low_cnt  <= '0;
            mute_cnt <= '0;
        end else begin
            low_cnt  <= (bus_clock_pin_i | bus_data_pin_i) ? '0 : low_cnt + 1;
            mute_cnt <= alarm_broadcast_en_o ? '0 : mute_cnt + 1;
        end
    end
    property p_crc_en;
        host_broadcast_crc_enable_o == cfg_host_crc_en_i &&
        charger_broadcast_crc_enable_o == cfg_charger_crc_en_i;
    endproperty
    a_crc_en: assert property (p_crc_en)
        else $error("broadcast crc enables differ from stored bits");
    property p_alarm;
        low_charge_alarm_o |-> charge_left_i != 16'hffff ||
                               $past(charge_left_i) != 16'hffff;
    endproperty
    a_alarm: assert property (p_alarm)
        else $error("low charge alarm with charge at full scale");
    property p_off;
        $rose(bus_off_o) |-> low_cnt >= OFF_CYCLES;
    endproperty
    a_off: assert property (p_off)
        else $error("bus off declared too early");
    property p_off_quiet;
        bus_off_o |-> !bus_data_pin_oe_o;
    endproperty
    a_off_quiet: assert property (p_off_quiet)
        else $error("data pin driven in bus off state");
    property p_on;
        bus_off_o && bus_clock_pin_i && bus_data_pin_i |-> ##[0:20] !bus_off_o;
    endproperty
    a_on: assert property (p_on)
        else $error("bus on state not detected in time");
    property p_mute;
        mute_cnt <= MUTE_CYCLES + 4;
    endproperty
    a_mute: assert property (p_mute)
        else $error("alarm broadcasts muted too long");
    property p_defaults;
        $rose(resetn_i) |->
            alarm_broadcast_en_o && charge_broadcast_en_o && !power_units_o;
    endproperty
    a_defaults: assert property (p_defaults)
        else $error("options defaults wrong after reset");
    property p_seal;
        !$fell(sealed_o);
    endproperty
    a_seal: assert property (p_seal)
        else $error("sealed state left without reset");
endmodule : sbcp_port_monitor

// ---- sbcp_host_model.sv ----
// Behavioural SMBus host driving the command port pins
`timescale 1ns/1ps
module sbcp_host_model (
    input  wire logic mclk_i,
    input  wire logic sda_i,
    output logic      scl_o,
    output logic      sda_oe_o
);
    // Idle: clock stands high, data left to the pull-up
    initial begin
        scl_o    = 1'b1;
        sda_oe_o = 1'b0;
    end
    task automatic hb();
        repeat (4) @(negedge mclk_i);
    endtask : hb
    // Also a repeated start when entered with the clock low
    task automatic start();
        sda_oe_o = 1'b0;
        hb();
        scl_o = 1'b1;
        hb();
        sda_oe_o = 1'b1;
        hb();
        scl_o = 1'b0;
    endtask : start
    task automatic stop();
        sda_oe_o = 1'b1;
        hb();
        scl_o = 1'b1;
        hb();
        sda_oe_o = 1'b0;
        hb();
    endtask : stop
    // Sampled late in the high phase: target answers lag the sync flops
    task automatic xbyte(input logic [7:0] d, input logic a,
                         output logic [7:0] q, output logic ack);
        logic [8:0] r;
        for (int i = 8; i >= 0; i--) begin
            repeat (2) @(negedge mclk_i);
            sda_oe_o = (i == 0) ? !a : !d[i-1];
            repeat (2) @(negedge mclk_i);
            scl_o = 1'b1;
            hb();
            r[i] = sda_i;
            scl_o = 1'b0;
        end
        q   = r[8:1];
        ack = !r[0];
    endtask : xbyte
    task automatic bus_level(input logic lvl);
        scl_o    = lvl;
        sda_oe_o = !lvl;
    endtask : bus_level
endmodule : sbcp_host_model

// ---- tb.sv ----
// Self-checking bench for the battery command port
`timescale 1ns/1ps
module tb
    import sbcp_pkg::*;
;
    localparam logic [15:0] DEV = 16'h5a3c; // Arbitrary value
    localparam logic [15:0] FW  = 16'h0207; // Arbitrary value
    localparam logic [6:0]  ADR = 7'h0b;
    localparam int OFF = 200, ON = 10, MUTE = 500;
    logic mclk_i = 0, resetn_i = 0, scl, h_oe, d_oe, sda, ok;
    logic hce, cce, cinc, fcu, ldone, hcrc, ccrc, lca, lra, abe, cbe, pu;
    logic sealed, boff, cerr;
    logic [15:0] lowchg, lowrun, end_of_discharge_voltage, cleft, rleft, v, t, o;
    int miscompares = 0;
    int num_checks = 0;
    assign sda = !(h_oe | d_oe);
    initial forever #50 mclk_i = ~mclk_i;
    sbcp_host_model host_u (.mclk_i(mclk_i), .sda_i(sda), .scl_o(scl),
        .sda_oe_o(h_oe));
    sbcp_port #(.DEVICE_TYPE(DEV), .FW_REVISION(FW), .OFF_CYCLES(OFF),
        .ON_CYCLES(ON), .MUTE_CYCLES(MUTE)) dut_u (
        .mclk_i(mclk_i), .resetn_i(resetn_i), .bus_clock_pin_i(scl),
        .bus_data_pin_i(sda), .bus_data_pin_o(), .bus_data_pin_oe_o(d_oe),
        .cfg_low_charge_i(lowchg), .cfg_low_runtime_i(lowrun),
        .cfg_host_crc_en_i(hce), .cfg_charger_crc_en_i(cce),
        .end_of_discharge_voltage_i(end_of_discharge_voltage), .charge_left_i(cleft),
        .mean_runtime_left_i(rleft), .cycle_count_inc_i(cinc),
        .full_capacity_update_i(fcu), .learn_done_i(ldone),
        .host_broadcast_crc_enable_o(hcrc),
        .charger_broadcast_crc_enable_o(ccrc), .low_charge_alarm_o(lca),
        .low_runtime_alarm_o(lra), .alarm_broadcast_en_o(abe),
        .charge_broadcast_en_o(cbe), .power_units_o(pu), .sealed_o(sealed),
        .bus_off_o(boff), .crc_error_o(cerr));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic complete_run();
        if (miscompares == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : complete_run
    function automatic logic [7:0] crc8(input logic [7:0] c,
        input logic [7:0] d);
        logic [7:0] r;
        r = c ^ d;
        for (int i = 0; i < 8; i++) r = r[7] ? (r << 1) ^ 8'h07 : r << 1;
        return r;
    endfunction : crc8
    // PEC mode: 0 none, 1 correct, 2 corrupted
    task automatic wr(input logic [6:0] a, input logic [7:0] cmd,
                      input logic [15:0] d, input int pec);
        logic [7:0] b [5];
        logic [7:0] c;
        logic [7:0] q;
        logic k;
        b = '{{a, 1'b0}, cmd, d[7:0], d[15:8], 8'h00};
        c = 8'h00;
        ok = 1'b1;
        host_u.start();
        for (int i = 0; i < 4 + (pec != 0); i++) begin
            if (i == 4) b[4] = (pec == 1) ? c : ~c;
            host_u.xbyte(b[i], 1'b1, q, k);
            c = crc8(c, b[i]);
            ok &= k;
        end
        host_u.stop();
    endtask : wr
    task automatic rd(input logic [7:0] cmd);
        logic [7:0] b [3];
        logic [7:0] q;
        logic k;
        host_u.start();
        host_u.xbyte({ADR, 1'b0}, 1'b1, q, k);
        host_u.xbyte(cmd, 1'b1, q, k);
        host_u.start();
        host_u.xbyte({ADR, 1'b1}, 1'b1, q, k);
        for (int i = 0; i < 3; i++) host_u.xbyte(8'hff, i == 2, b[i], k);
        host_u.stop();
        v = {b[1], b[0]};
        chk(b[2], crc8(crc8(crc8(crc8(crc8(8'h00, {ADR, 1'b0}), cmd),
            {ADR, 1'b1}), b[0]), b[1]));
    endtask : rd
    task automatic incs(input int n);
        repeat (n) begin
            cinc = 1'b1;
            @(negedge mclk_i);
            cinc = 1'b0;
            @(negedge mclk_i);
        end
    endtask : incs
    initial begin
        void'($urandom(32'hb50f117b));
        {hce, cce, cinc, fcu, ldone} = '0;
        lowchg = $urandom;
        lowrun = $urandom;
        end_of_discharge_voltage = $urandom;
        {cleft, rleft} = '1;
        repeat (5) @(negedge mclk_i);
        resetn_i = 1'b1;
        repeat (4) @(negedge mclk_i);
        rd(8'h01); chk(v, lowchg);
        rd(8'h02); chk(v, lowrun);
        rd(8'h03); chk(v, 16'h0080);
        for (int i = 0; i < 4; i++) begin
            {hce, cce} = i[1:0];
            @(negedge mclk_i);
            chk({hcrc, ccrc}, i[1:0]);
        end
        for (int i = 1; i <= 3; i++) begin
            wr(ADR, 8'h00, i[15:0], 0);
            rd(8'h00); chk(v, i == 1 ? DEV : i == 2 ? FW : end_of_discharge_voltage);
        end
        for (int i = 0; i < 3; i++) begin
            o = (i == 0) ? 16'hffff : $urandom;
            wr(ADR, 8'h03, o, 1); chk(ok, 1'b1);
            chk(abe, 1'b0);
            chk({pu, cbe}, {o[15], !o[14]});
            rd(8'h03); chk(v, {o[15:14], 6'h00, 8'h80});
        end
        repeat (MUTE) @(negedge mclk_i);
        chk(abe, 1'b1);
        for (int i = 0; i < 2; i++) begin
            t = $urandom_range(16'hfffe, 1);
            wr(ADR, 8'h01 + i[7:0], t, 0);
            rd(8'h01 + i[7:0]); chk(v, t);
            {cleft, rleft} = {2{t - 16'h0001}};
            repeat (2) @(negedge mclk_i);
            chk(i ? lra : lca, 1'b1);
            {cleft, rleft} = {t, t};
            repeat (2) @(negedge mclk_i);
            chk(i ? lra : lca, 1'b0);
            wr(ADR, 8'h01 + i[7:0], 16'h0000, 0);
            {cleft, rleft} = '0;
            repeat (2) @(negedge mclk_i);
            chk(i ? lra : lca, 1'b0);
        end
        wr(ADR, 8'h01, 16'h1234, 2); chk(ok, 1'b0);
        chk(cerr, 1'b1);
        wr(7'h0a, 8'h01, 16'h0000, 0); chk(ok, 1'b0);
        rd(8'h01); chk(v, 16'h1234);
        ldone = 1'b1;
        @(negedge mclk_i);
        ldone = 1'b0;
        incs(10);
        fcu = 1'b1;
        @(negedge mclk_i);
        fcu = 1'b0;
        incs(19);
        rd(8'h03); chk(v[7], 1'b0);
        incs(1);
        rd(8'h03); chk(v[7], 1'b1);
        host_u.bus_level(1'b0);
        repeat (OFF - 10) @(negedge mclk_i);
        chk(boff, 1'b0);
        repeat (20) @(negedge mclk_i);
        chk(boff, 1'b1);
        host_u.bus_level(1'b1);
        repeat (ON + 8) @(negedge mclk_i);
        chk(boff, 1'b0);
        rd(8'h02); chk(v, 16'h0000);
        wr(ADR, 8'h00, 16'h062b, 0);
        chk(sealed, 1'b1);
        rd(8'h00); chk(v, 16'h0000);
        complete_run();
    end
    initial begin
        repeat (60000) @(posedge mclk_i);
        miscompares++;
        complete_run();
    end
endmodule : tb
bind sbcp_port sbcp_port_monitor #(.OFF_CYCLES(OFF_CYCLES),
    .MUTE_CYCLES(MUTE_CYCLES)) mon_u (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .bus_clock_pin_i(bus_clock_pin_i),
    .bus_data_pin_i(bus_data_pin_i), .bus_data_pin_oe_o(bus_data_pin_oe_o),
    .cfg_host_crc_en_i(cfg_host_crc_en_i),
    .cfg_charger_crc_en_i(cfg_charger_crc_en_i),
    .charge_left_i(charge_left_i),
    .host_broadcast_crc_enable_o(host_broadcast_crc_enable_o),
    .charger_broadcast_crc_enable_o(charger_broadcast_crc_enable_o),
    .low_charge_alarm_o(low_charge_alarm_o),
    .alarm_broadcast_en_o(alarm_broadcast_en_o),
    .charge_broadcast_en_o(charge_broadcast_en_o),
    .power_units_o(power_units_o), .sealed_o(sealed_o), .bus_off_o(bus_off_o));
